// >>> include/pcr_consts.vh
// Constants for the cyclic retransmission error correction block
`ifndef PCR_CONSTS_VH
`define PCR_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define PCR_OFS_N1_LIMIT   8'h00
`define PCR_OFS_N2_LIMIT   8'h04
`define PCR_OFS_T7_MS      8'h08
`define PCR_OFS_STATUS     8'h0c
`define PCR_OFS_OCTETS     8'h10

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define PCR_ST_HELD_LSB    0
`define PCR_ST_FORCED_BIT  8
`define PCR_ST_FAULTY_BIT  9
`define PCR_ST_FAIL_BIT    10

// ----------------------------------------------------------------
// Reset values and fixed figures
// ----------------------------------------------------------------
`define PCR_N1_MAX         7'h7f
`define PCR_N1_RESET       7'h7f
`define PCR_N2_RESET       16'h0100
`define PCR_T7_MS_RESET    16'h03e8
`define PCR_SEQ_MOD        128
`define PCR_CLK_MHZ        125
`define PCR_US_PER_MS      1000

`endif

// >>> logic/ack_delay_timer.v
// Acknowledgement delay timer with millisecond tick divider
`timescale 1ns/1ps
`default_nettype none
`include "pcr_consts.vh"

module ack_delay_timer #(
  parameter TICK_CYCLES = `PCR_CLK_MHZ * `PCR_US_PER_MS
) (
  input  wire        core_clk_i,
  input  wire        rst_b_i,
  input  wire        run_i,
  input  wire        restart_i,
  input  wire [15:0] timeout_ms_i,
  output wire        expire_o
);

  reg  [16:0] div_q;
  reg  [15:0] ms_q;
  reg         fired_q;
  wire        tick;

  assign tick     = (div_q == TICK_CYCLES[16:0] - 17'h00001);
  assign expire_o = run_i && !restart_i && !fired_q && tick && (ms_q + 16'h0001 >= timeout_ms_i);

  // Fires once per stall; a new ack or an empty buffer rearms it
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_q   <= 17'h00000;
      ms_q    <= 16'h0000;
      fired_q <= 1'b0;
    end else if (!run_i || restart_i) begin
      div_q   <= 17'h00000;
      ms_q    <= 16'h0000;
      fired_q <= 1'b0;
    end else begin
      div_q <= tick ? 17'h00000 : div_q + 17'h00001;
      if (tick && !fired_q)
        ms_q <= ms_q + 16'h0001;
      if (expire_o)
        fired_q <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// >>> logic/bsn_fault_monitor.v
// Unreasonable backward sequence number monitor
`timescale 1ns/1ps
`default_nettype none

module bsn_fault_monitor (
  input  wire core_clk_i,
  input  wire rst_b_i,
  input  wire unit_i,
  input  wire bad_i,
  output wire discard_o,
  output wire faulty_o
);

  reg [1:0] hist_q;
  reg       skip_q;

  // A bad unit is dropped and so is the next checked unit
  assign discard_o = unit_i && (bad_i || skip_q);
  // Two bad in any window of three consecutive units
  assign faulty_o  = unit_i && bad_i && (hist_q[0] || hist_q[1]);

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hist_q <= 2'b00;
      skip_q <= 1'b0;
    end else if (unit_i) begin
      hist_q <= {hist_q[0], bad_i};
      skip_q <= bad_i;
    end
  end

endmodule
`default_nettype wire

// >>> logic/pcr_error_corr.v
// Preventive cyclic retransmission error correction core with AHB-Lite registers
//
// The register addresses and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pcr_consts.vh"

// Behaviour
// - Every sent message unit is held until a covering acknowledgement arrives.
// - With nothing new to send, held message units are resent cyclically.
// - A new unit waiting preempts the cyclic retransmission.
// - Nothing to send or resend: fill-in units go out continuously.
// - New message unit number is previous plus one, modulo 128.
// - Other units carry the number of the last sent message unit.
// - Octet, field, number and length kept; number reused only after acknowledgement.
// - Indicator bits sent as one and ignored on reception.
// - Length indicator splits units; non-message units go on unless dropped by the backward number check.
// - A message unit is delivered only when its number is next in sequence.
// - Repeated or out-of-sequence message units are discarded.
// - Acknowledgement processing covers message and fill-in units with reasonable numbers.
// - Backward number sent is the latest accepted number, kept until the next.
// - A matching acknowledgement releases that unit and all older ones.
// - A repeated acknowledgement value causes no further action.
// - Unreasonable backward number: drop that unit and the next checked unit.
// - Two unreasonable numbers in three checked units signal a faulty link.
// - Timer runs while units held; expiry without new acknowledgement reports failure.
// - Held unit count and held octet count are tracked against limits.
// - At a limit, resend held units with priority in order through the newest.
// - After a forced pass, resume normal if under limits, else repeat.
// - Held unit limit never exceeds 127.
// - Held octet limit is software set from loop delay over octet time.
module pcr_error_corr #(
  parameter DATA_W      = 32,
  parameter TICK_CYCLES = `PCR_CLK_MHZ * `PCR_US_PER_MS
) (
  input  wire              core_clk_i,
  input  wire              rst_b_i,
  // AHB-Lite slave
  input  wire              hsel_i,
  input  wire [7:0]        haddr_i,
  input  wire [1:0]        htrans_i,
  input  wire              hwrite_i,
  input  wire [2:0]        hsize_i,
  input  wire [31:0]       hwdata_i,
  input  wire              hready_i,
  output wire [31:0]       hrdata_o,
  output wire              hreadyout_o,
  output wire              hresp_o,
  // New message units from level 3
  input  wire              tx_valid_i,
  output wire              tx_ready_o,
  input  wire [7:0]        tx_sio_i,
  input  wire [5:0]        tx_li_i,
  input  wire [DATA_W-1:0] tx_data_i,
  // Units toward the data link
  input  wire              out_ready_i,
  output wire              out_valid_o,
  output wire [6:0]        out_fsn_o,
  output wire [6:0]        out_bsn_o,
  output wire              out_fib_o,
  output wire              out_bib_o,
  output wire [5:0]        out_li_o,
  output wire [7:0]        out_sio_o,
  output wire [DATA_W-1:0] out_data_o,
  // Units from the data link, already checked
  input  wire              in_valid_i,
  input  wire              in_crc_ok_i,
  input  wire [6:0]        in_fsn_i,
  input  wire [6:0]        in_bsn_i,
  input  wire              in_fib_i,
  input  wire              in_bib_i,
  input  wire [5:0]        in_li_i,
  input  wire [7:0]        in_sio_i,
  input  wire [DATA_W-1:0] in_data_i,
  // Deliveries upward
  output wire              rx_valid_o,
  output wire [7:0]        rx_sio_o,
  output wire [5:0]        rx_li_o,
  output wire [DATA_W-1:0] rx_data_o,
  output wire              mtp_valid_o,
  output wire [5:0]        mtp_li_o,
  output wire              link_faulty_o,
  output wire              link_fail_o
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  localparam ST_NORMAL = 1'b0;
  localparam ST_FORCED = 1'b1;

  // True when x lies in (base, base+cnt] modulo 128
  function in_window;
    input [6:0] x;
    input [6:0] base;
    input [6:0] cnt;
    reg   [6:0] d;
    begin
      d         = x - base;
      in_window = (d != 7'h00) && (d <= cnt);
    end
  endfunction

  // ----------------------------------------------------------------
  // Held unit store
  // ----------------------------------------------------------------
  reg  [DATA_W-1:0] mem_data [0:`PCR_SEQ_MOD-1];
  reg  [7:0]        mem_sio  [0:`PCR_SEQ_MOD-1];
  reg  [5:0]        mem_li   [0:`PCR_SEQ_MOD-1];

  reg  [6:0]        last_asg_q;
  reg  [6:0]        last_ack_q;
  reg  [6:0]        ack_tgt_q;
  reg  [6:0]        last_tx_fsn_q;
  reg  [6:0]        rtx_ptr_q;
  reg  [6:0]        forced_end_q;
  reg               state_q;
  reg  [15:0]       octets_q;

  reg  [6:0]        n1_lim_q;
  reg  [15:0]       n2_lim_q;
  reg  [15:0]       t7_ms_q;
  reg               faulty_st_q;
  reg               fail_st_q;

  reg               out_valid_q;
  reg  [6:0]        out_fsn_q;
  reg  [5:0]        out_li_q;
  reg  [7:0]        out_sio_q;
  reg  [DATA_W-1:0] out_data_q;
  reg  [6:0]        rx_last_q;
  reg               rx_valid_q;
  reg  [7:0]        rx_sio_q;
  reg  [5:0]        rx_li_q;
  reg  [DATA_W-1:0] rx_data_q;
  reg               mtp_valid_q;
  reg  [5:0]        mtp_li_q;

  wire [6:0] held      = last_asg_q - last_ack_q;
  wire [6:0] pend      = last_asg_q - ack_tgt_q;
  wire [6:0] oldest    = last_ack_q + 7'h01;
  wire       releasing = (ack_tgt_q != last_ack_q);

  wire       limit_hit = (held >= n1_lim_q) || (octets_q >= n2_lim_q) || (held == `PCR_N1_MAX);

  // ----------------------------------------------------------------
  // Transmit selection
  // ----------------------------------------------------------------
  wire       load     = !out_valid_q || out_ready_i;
  wire [6:0] ptr_use  = in_window(rtx_ptr_q, last_ack_q, held) ? rtx_ptr_q : oldest;
  wire       forced   = (held != 7'h00) && (state_q == ST_FORCED || limit_hit);
  wire [6:0] end_use  = (state_q == ST_FORCED) ? forced_end_q : last_asg_q;
  wire       end_hit  = (ptr_use == end_use) || !in_window(end_use, last_ack_q, held);
  wire       send_new = !forced && tx_valid_i;
  wire       send_rtx = forced || (!tx_valid_i && held != 7'h00);
  wire [6:0] new_fsn  = last_asg_q + 7'h01;

  assign tx_ready_o = load && send_new;

  always @(posedge core_clk_i) begin
    if (load && send_new) begin
      mem_data[new_fsn] <= tx_data_i;
      mem_sio[new_fsn]  <= tx_sio_i;
      mem_li[new_fsn]   <= tx_li_i;
    end
  end

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_valid_q   <= 1'b0;
      out_fsn_q     <= 7'h7f;
      out_li_q      <= 6'h00;
      out_sio_q     <= 8'h00;
      out_data_q    <= {DATA_W{1'b0}};
      last_asg_q    <= 7'h7f;
      last_tx_fsn_q <= 7'h7f;
      rtx_ptr_q     <= 7'h00;
      forced_end_q  <= 7'h7f;
      state_q       <= ST_NORMAL;
    end else if (load) begin
      out_valid_q <= 1'b1;
      if (send_new) begin
        last_asg_q    <= new_fsn;
        last_tx_fsn_q <= new_fsn;
        out_fsn_q     <= new_fsn;
        out_li_q      <= tx_li_i;
        out_sio_q     <= tx_sio_i;
        out_data_q    <= tx_data_i;
      end else if (send_rtx) begin
        last_tx_fsn_q <= ptr_use;
        out_fsn_q     <= ptr_use;
        out_li_q      <= mem_li[ptr_use];
        out_sio_q     <= mem_sio[ptr_use];
        out_data_q    <= mem_data[ptr_use];
        rtx_ptr_q     <= ptr_use + 7'h01;
      end else begin
        out_fsn_q  <= last_tx_fsn_q;
        out_li_q   <= 6'h00;
        out_sio_q  <= 8'h00;
        out_data_q <= {DATA_W{1'b0}};
      end
      if (!forced) begin
        state_q <= ST_NORMAL;
      end else if (!end_hit) begin
        state_q      <= ST_FORCED;
        forced_end_q <= end_use;
      end else if (limit_hit) begin
        state_q      <= ST_FORCED;
        forced_end_q <= last_asg_q;
        rtx_ptr_q    <= oldest;
      end else begin
        state_q <= ST_NORMAL;
      end
    end
  end

  assign out_valid_o = out_valid_q;
  assign out_fsn_o   = out_fsn_q;
  assign out_bsn_o   = rx_last_q;
  assign out_fib_o   = 1'b1;
  assign out_bib_o   = 1'b1;
  assign out_li_o    = out_li_q;
  assign out_sio_o   = out_sio_q;
  assign out_data_o  = out_data_q;

  // ----------------------------------------------------------------
  // Receive side
  // ----------------------------------------------------------------
  // Indicator bits are deliberately left unread
  wire in_ok     = in_valid_i && in_crc_ok_i;
  wire in_is_msu = (in_li_i > 6'h02);
  wire in_is_lss = (in_li_i == 6'h01) || (in_li_i == 6'h02);
  wire bsn_unit  = in_ok && !in_is_lss;
  wire bsn_same  = (in_bsn_i == ack_tgt_q);
  wire bsn_bad   = !bsn_same && !in_window(in_bsn_i, ack_tgt_q, pend);
  wire discard;
  wire faulty;
  wire new_ack   = bsn_unit && !discard && !bsn_same;
  wire accept    = bsn_unit && in_is_msu && !discard && (in_fsn_i == rx_last_q + 7'h01);
  wire fail;

  bsn_fault_monitor u_mon (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .unit_i     (bsn_unit),
    .bad_i      (bsn_bad),
    .discard_o  (discard),
    .faulty_o   (faulty)
  );

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_last_q   <= 7'h7f;
      rx_valid_q  <= 1'b0;
      rx_sio_q    <= 8'h00;
      rx_li_q     <= 6'h00;
      rx_data_q   <= {DATA_W{1'b0}};
      mtp_valid_q <= 1'b0;
      mtp_li_q    <= 6'h00;
    end else begin
      rx_valid_q  <= accept;
      mtp_valid_q <= in_ok && !in_is_msu && !(bsn_unit && discard);
      if (accept) begin
        rx_last_q <= in_fsn_i;
        rx_sio_q  <= in_sio_i;
        rx_li_q   <= in_li_i;
        rx_data_q <= in_data_i;
      end
      if (in_ok && !in_is_msu)
        mtp_li_q <= in_li_i;
    end
  end

  assign rx_valid_o  = rx_valid_q;
  assign rx_sio_o    = rx_sio_q;
  assign rx_li_o     = rx_li_q;
  assign rx_data_o   = rx_data_q;
  assign mtp_valid_o = mtp_valid_q;
  assign mtp_li_o    = mtp_li_q;

  // ----------------------------------------------------------------
  // Acknowledgement release, one unit per cycle
  // ----------------------------------------------------------------
  wire [15:0] add_oct = (load && send_new) ? {10'h000, tx_li_i} : 16'h0000;
  wire [15:0] sub_oct = releasing ? {10'h000, mem_li[oldest]} : 16'h0000;

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_tgt_q  <= 7'h7f;
      last_ack_q <= 7'h7f;
      octets_q   <= 16'h0000;
    end else begin
      if (new_ack)
        ack_tgt_q <= in_bsn_i;
      if (releasing)
        last_ack_q <= oldest;
      octets_q <= octets_q + add_oct - sub_oct;
    end
  end

  ack_delay_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_t7 (
    .core_clk_i   (core_clk_i),
    .rst_b_i      (rst_b_i),
    .run_i        (pend != 7'h00),
    .restart_i    (new_ack),
    .timeout_ms_i (t7_ms_q),
    .expire_o     (fail)
  );

  assign link_faulty_o = faulty;
  assign link_fail_o   = fail;

  // ----------------------------------------------------------------
  // AHB-Lite register slave, zero wait states
  // ----------------------------------------------------------------
  reg        wr_pend_q;
  reg  [7:0] wr_addr_q;
  reg [31:0] hrdata_q;
  reg [31:0] rd_mux;
  wire       addr_ph = hsel_i && hready_i && htrans_i[1];
  wire       wr_stat = wr_pend_q && (wr_addr_q == `PCR_OFS_STATUS);

  always @* begin
    case (haddr_i)
      `PCR_OFS_N1_LIMIT: rd_mux = {25'h0000000, n1_lim_q};
      `PCR_OFS_N2_LIMIT: rd_mux = {16'h0000, n2_lim_q};
      `PCR_OFS_T7_MS:    rd_mux = {16'h0000, t7_ms_q};
      `PCR_OFS_STATUS:   rd_mux = {21'h000000, fail_st_q, faulty_st_q, state_q, 1'b0, held};
      `PCR_OFS_OCTETS:   rd_mux = {16'h0000, octets_q};
      default:           rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= 8'h00;
      hrdata_q    <= 32'h00000000;
      n1_lim_q    <= `PCR_N1_RESET;
      n2_lim_q    <= `PCR_N2_RESET;
      t7_ms_q     <= `PCR_T7_MS_RESET;
      faulty_st_q <= 1'b0;
      fail_st_q   <= 1'b0;
    end else begin
      if (hready_i) begin
        wr_pend_q <= addr_ph && hwrite_i;
        wr_addr_q <= haddr_i;
      end
      if (addr_ph && !hwrite_i)
        hrdata_q <= rd_mux;
      if (wr_pend_q && wr_addr_q == `PCR_OFS_N1_LIMIT)
        n1_lim_q <= (hwdata_i[6:0] == 7'h00) ? 7'h01 : hwdata_i[6:0];
      if (wr_pend_q && wr_addr_q == `PCR_OFS_N2_LIMIT)
        n2_lim_q <= hwdata_i[15:0];
      if (wr_pend_q && wr_addr_q == `PCR_OFS_T7_MS)
        t7_ms_q <= hwdata_i[15:0];
      // Hardware set wins over a same-cycle write-one clear
      faulty_st_q <= faulty || (faulty_st_q && !(wr_stat && hwdata_i[`PCR_ST_FAULTY_BIT]));
      fail_st_q   <= fail || (fail_st_q && !(wr_stat && hwdata_i[`PCR_ST_FAIL_BIT]));
    end
  end

  assign hrdata_o    = hrdata_q;
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

endmodule
`default_nettype wire

// >>> bench/pcr_checker.sv
// Concurrent checks on the ports of the retransmission core
`timescale 1ns/1ps
`default_nettype none
module pcr_checker (
  input wire logic       core_clk_i,
  input wire logic       rst_b_i,
  input wire logic       tx_valid_i,
  input wire logic       tx_ready_o,
  input wire logic [5:0] tx_li_i,
  input wire logic       out_valid_o,
  input wire logic       out_ready_i,
  input wire logic [6:0] out_fsn_o,
  input wire logic [5:0] out_li_o,
  input wire logic       out_fib_o,
  input wire logic       out_bib_o,
  input wire logic [6:0] out_bsn_o,
  input wire logic       in_valid_i,
  input wire logic       in_crc_ok_i,
  input wire logic [6:0] in_fsn_i,
  input wire logic [5:0] in_li_i,
  input wire logic       rx_valid_o,
  input wire logic [5:0] rx_li_o,
  input wire logic       mtp_valid_o,
  input wire logic [5:0] mtp_li_o,
  input wire logic       link_faulty_o
);
  logic [6:0] next_fsn_q;
  logic [6:0] last_acc_q;
  logic [6:0] in_fsn_q;
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // ------------------------------------------------
  // Expected numbering, own copy
  // ------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      next_fsn_q <= 7'h00;
      last_acc_q <= 7'h7f;
      in_fsn_q   <= 7'h00;
    end else begin
      in_fsn_q <= in_fsn_i;
      if (tx_valid_i && tx_ready_o) next_fsn_q <= next_fsn_q + 7'h01;
      if (rx_valid_o) last_acc_q <= in_fsn_q;
    end
  end
  sequence s_take;
    tx_valid_i && tx_ready_o;
  endsequence
  sequence s_stalled;
    out_valid_o && !out_ready_i;
  endsequence
  property p_fib_bib;
    out_valid_o |-> out_fib_o && out_bib_o;
  endproperty
  property p_new_unit;
    s_take |=> out_fsn_o == $past(next_fsn_q) && out_li_o == $past(tx_li_i);
  endproperty
  property p_hold;
    s_stalled |=> $stable(out_fsn_o) && $stable(out_li_o);
  endproperty
  property p_rx_src;
    rx_valid_o |-> $past(in_valid_i && in_crc_ok_i && in_li_i > 6'd2) && rx_li_o == $past(in_li_i);
  endproperty
  property p_rx_seq;
    rx_valid_o |-> $past(in_fsn_i) == last_acc_q + 7'h01;
  endproperty
  property p_bsn;
    !rx_valid_o && !$past(rx_valid_o) |-> out_bsn_o == last_acc_q;
  endproperty
  property p_mtp;
    mtp_valid_o |-> $past(in_valid_i && in_crc_ok_i && in_li_i <= 6'd2) && mtp_li_o == $past(in_li_i);
  endproperty
  property p_faulty;
    link_faulty_o |-> in_valid_i && in_crc_ok_i;
  endproperty
  a_fib_bib: assert property (p_fib_bib) else $error("indicator bit low");
  a_new_unit: assert property (p_new_unit) else $error("new unit number or length");
  a_hold: assert property (p_hold) else $error("unit changed while stalled");
  a_rx_src: assert property (p_rx_src) else $error("delivery without message");
  a_rx_seq: assert property (p_rx_seq) else $error("delivery out of sequence");
  a_bsn: assert property (p_bsn) else $error("backward number wrong");
  a_mtp: assert property (p_mtp) else $error("non-message pass-on wrong");
  a_faulty: assert property (p_faulty) else $error("faulty without unit");
endmodule
bind pcr_error_corr pcr_checker u_chk (.*);
`default_nettype wire

// >>> bench/peer_terminal.sv
// Far-end link terminal: takes units, sends checked units back
`timescale 1ns/1ps
`default_nettype none
module peer_terminal (
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        stall_i,
  input  wire logic        out_valid_i,
  input  wire logic [6:0]  out_fsn_i,
  input  wire logic [5:0]  out_li_i,
  output logic             out_ready_o,
  output logic             in_valid_o,
  output logic             in_crc_ok_o,
  output logic [6:0]       in_fsn_o,
  output logic [6:0]       in_bsn_o,
  output logic             in_fib_o,
  output logic             in_bib_o,
  output logic [5:0]       in_li_o,
  output logic [7:0]       in_sio_o,
  output logic [31:0]      in_data_o
);
  logic [6:0] seen_q[$];
  int         n_fill = 0;
  assign out_ready_o = !stall_i;
  assign in_fib_o    = 1'b1;
  assign in_bib_o    = 1'b1;
  initial begin
    {in_valid_o, in_fsn_o, in_bsn_o, in_li_o, in_sio_o, in_data_o} = '0;
    in_crc_ok_o = 1'b1;
  end
  always @(posedge core_clk_i) begin
    if (rst_b_i && out_valid_i && out_ready_o) begin
      if (out_li_i > 6'd2) seen_q.push_back(out_fsn_i);
      else if (out_li_i == 6'd0) n_fill++;
    end
  end
  // Length, number and data lines are inverted outside the valid cycle so stale values never match
  task automatic send(input logic [5:0] li, input logic [6:0] fsn, input logic [6:0] bsn, input logic ok);
    @(posedge core_clk_i);
    in_valid_o  <= 1'b1;
    in_crc_ok_o <= ok;
    in_li_o     <= li;
    in_fsn_o    <= fsn;
    in_bsn_o    <= bsn;
    in_sio_o    <= {2'b00, li};
    in_data_o   <= {25'h0, fsn};
    @(posedge core_clk_i);
    in_valid_o  <= 1'b0;
    in_li_o     <= ~li;
    in_fsn_o    <= ~fsn;
    in_bsn_o    <= ~bsn;
    in_data_o   <= ~in_data_o;
  endtask
endmodule
`default_nettype wire

// >>> bench/tb_cyclic_retransmission_error_correction.sv
// Self-checking bench for the retransmission core
`timescale 1ns/1ps
`default_nettype none
module tb_cyclic_retransmission_error_correction;
  logic        core_clk_i, rst_b_i, hsel_i, hwrite_i, hready_i, tx_valid_i, out_ready_i, in_valid_i;
  logic        in_crc_ok_i, in_fib_i, in_bib_i, hreadyout_o, hresp_o, tx_ready_o, out_valid_o, stall;
  logic        out_fib_o, out_bib_o, rx_valid_o, mtp_valid_o, link_faulty_o, link_fail_o;
  logic [7:0]  haddr_i, tx_sio_i, out_sio_o, in_sio_i, rx_sio_o;
  logic [1:0]  htrans_i;
  logic [2:0]  hsize_i;
  logic [31:0] hwdata_i, hrdata_o, tx_data_i, out_data_o, in_data_i, rx_data_o, rd;
  logic [5:0]  tx_li_i, out_li_o, in_li_i, rx_li_o, mtp_li_o;
  logic [6:0]  out_fsn_o, out_bsn_o, in_fsn_i, in_bsn_i;
  int          n_errors = 0, n_compared = 0, n_rx = 0, n_mtp = 0, n_flt = 0, n_fail = 0, cyc = 0;
  int          k, j, f0, m0;
  assign hready_i = hreadyout_o;
  pcr_error_corr #(.TICK_CYCLES(10)) DUT (.*);
  peer_terminal peer (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .stall_i(stall), .out_valid_i(out_valid_o),
    .out_fsn_i(out_fsn_o), .out_li_i(out_li_o), .out_ready_o(out_ready_i), .in_valid_o(in_valid_i),
    .in_crc_ok_o(in_crc_ok_i), .in_fsn_o(in_fsn_i), .in_bsn_o(in_bsn_i), .in_fib_o(in_fib_i),
    .in_bib_o(in_bib_i), .in_li_o(in_li_i), .in_sio_o(in_sio_i), .in_data_o(in_data_i));
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cyc++;
    n_rx += (rx_valid_o === 1'b1);
    n_mtp += (mtp_valid_o === 1'b1);
    n_flt += (link_faulty_o === 1'b1);
    n_fail += (link_fail_o === 1'b1);
    if (cyc == 20000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t value mismatch got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    @(posedge core_clk_i);
    hsel_i   <= 1'b1;
    htrans_i <= 2'b10;
    haddr_i  <= a;
    hwrite_i <= wr;
    do @(posedge core_clk_i); while (hready_i !== 1'b1);
    htrans_i <= 2'b00;
    hwdata_i <= wd;
    do @(posedge core_clk_i); while (hready_i !== 1'b1);
    r = hrdata_o;
  endtask
  // Releases drain one unit per cycle, so let them settle before reading status
  task automatic stat;
    repeat (8) @(posedge core_clk_i);
    ahb(0, 8'h0c, 0, rd);
  endtask
  task automatic tx(input int n, input logic [5:0] li);
    for (int i = 0; i < n; i++) begin
      @(posedge core_clk_i);
      tx_valid_i <= 1'b1;
      tx_li_i    <= li;
      tx_sio_i   <= 8'(i);
      tx_data_i  <= 32'(i);
      do @(negedge core_clk_i); while (tx_ready_o !== 1'b1);
    end
    @(posedge core_clk_i);
    tx_valid_i <= 1'b0;
  endtask
  task tally_and_finish;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  initial begin
    {rst_b_i, hsel_i, htrans_i, hwrite_i, haddr_i, hwdata_i, tx_valid_i, tx_sio_i, tx_li_i, tx_data_i, stall} = '0;
    hsize_i = 3'h2;
    repeat (4) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    ahb(0, 8'h04, 0, rd);
    chk(rd, 32'h100);
    ahb(0, 8'h20, 0, rd);
    chk(rd, 32'h0);
    ahb(1, 8'h00, 32'hff, rd);
    ahb(0, 8'h00, 0, rd);
    chk(rd, 32'h7f);
    ahb(1, 8'h08, 32'h5, rd);
    chk(out_li_o, 0);
    chk(out_fsn_o, 7'h7f);
    tx(3, 6'd5);
    stall <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    stall <= 1'b0;
    repeat (3) @(negedge core_clk_i);
    chk(out_sio_o, 1);
    chk(out_data_o, 1);
    chk(out_li_o, 5);
    for (k = 0; k < 100 && peer.seen_q.size() < 9; k++) @(posedge core_clk_i);
    for (k = 0; k < 9; k++) chk(peer.seen_q[k], k % 3);
    tx(1, 6'd4);
    @(negedge core_clk_i);
    chk(out_fsn_o, 7'h03);
    peer.send(0, 7'h7f, 7'h01, 1'b1);
    stat;
    chk(rd[6:0], 2);
    peer.send(0, 7'h7f, 7'h01, 1'b1);
    peer.send(0, 7'h7f, 7'h01, 1'b1);
    stat;
    chk(rd[6:0], 2);
    peer.send(0, 7'h7f, 7'h03, 1'b1);
    stat;
    chk(rd[6:0], 0);
    chk(out_li_o, 0);
    chk(out_fsn_o, peer.seen_q[$]);
    f0 = n_rx;
    m0 = n_mtp;
    peer.send(5, 7'h00, 7'h03, 1'b1);
    peer.send(5, 7'h00, 7'h03, 1'b1);
    peer.send(5, 7'h05, 7'h03, 1'b1);
    peer.send(5, 7'h01, 7'h03, 1'b0);
    peer.send(6, 7'h01, 7'h03, 1'b1);
    peer.send(0, 7'h01, 7'h03, 1'b1);
    repeat (3) @(posedge core_clk_i);
    chk(n_rx - f0, 2);
    chk(n_mtp - m0, 1);
    chk(out_bsn_o, 7'h01);
    chk(rx_li_o, 6);
    chk(rx_sio_o, 6);
    chk(rx_data_o, 1);
    peer.send(0, 7'h01, 7'h50, 1'b1);
    peer.send(5, 7'h02, 7'h03, 1'b1);
    peer.send(0, 7'h01, 7'h50, 1'b1);
    peer.send(0, 7'h01, 7'h03, 1'b1);
    repeat (3) @(posedge core_clk_i);
    chk(n_rx - f0, 2);
    chk(n_mtp - m0, 1);
    chk(n_flt, 1);
    stat;
    chk(rd[9], 1);
    f0 = n_fail;
    tx(1, 6'd4);
    for (k = 0; k < 200 && n_fail == f0; k++) @(posedge core_clk_i);
    chk(n_fail - f0, 1);
    chk(k inside {[40:60]}, 1);
    peer.send(0, 7'h01, 7'h04, 1'b1);
    for (j = 0; j < 2; j++) begin
      ahb(1, 8'h00, j ? 32'h7f : 32'h2, rd);
      ahb(1, 8'h04, j ? 32'h8 : 32'h100, rd);
      tx(2, 6'd5);
      f0 = peer.n_fill;
      repeat (20) @(posedge core_clk_i);
      chk(peer.n_fill - f0, 0);
      stat;
      chk(rd[8], 1);
      @(posedge core_clk_i);
      tx_valid_i <= 1'b1;
      @(negedge core_clk_i);
      chk(tx_ready_o, 0);
      @(posedge core_clk_i);
      tx_valid_i <= 1'b0;
      peer.send(0, 7'h01, 7'(6 + 2 * j), 1'b1);
      repeat (6) @(posedge core_clk_i);
      stat;
      chk(rd[8:0], 0);
    end
    tally_and_finish;
  end
endmodule
`default_nettype wire
